// ---- hw/pdm_pkg.sv ----
// package for the port d / port e pin function mux
// assumes one core clock domain and synchronous active-high reset
package pdm_pkg;
  // ==========================================================
  // widths and bit positions
  localparam int unsigned PD_LINES = 6;
  localparam int unsigned PE_LINES = 2;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned SEL_CAN_TX_BIT = 4;
  localparam int unsigned SEL_CAN_RX_BIT = 5;
  localparam int unsigned PSEL_WIDTH = 16;
  // ==========================================================
  // reset values
  localparam logic [5:0] PD_PER_RESET = 6'h00;
  localparam logic [1:0] PE_PER_RESET = 2'h3;
  localparam logic [5:0] PD_PULL_RESET = 6'h3f;
  localparam logic [1:0] PE_PULL_RESET = 2'h3;
  localparam logic [15:0] PSEL_RESET = 16'h0000;
  localparam logic BUS_IDLE_DRIVE_RESET = 1'b0;
  // ==========================================================
  // pad bundle: one entry per pin
  typedef struct packed {
    logic out;
    logic oe;
    logic pull;
  } pdm_pad_type;
  // ==========================================================
  // registered configuration image
  typedef struct packed {
    logic [5:0] pd_per;
    logic [1:0] pe_per;
    logic [5:0] pd_pull;
    logic [1:0] pe_pull;
    logic can_tx_sel;
    logic can_rx_sel;
    logic bus_idle_drive;
  } pdm_cfg_type;
endpackage : pdm_pkg

// ---- hw/pdm_sync.sv ----
// three-stage synchroniser with agreement filter
// assumes asynchronous pad inputs, one clock domain
`timescale 1ns/1ps
module pdm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] val;
  } pdm_sync_state_type;

  pdm_sync_state_type st_q;
  pdm_sync_state_type st_d;

  // ==========================================================
  // first stage is only read by the second
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.val[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.val;
endmodule : pdm_sync

// ---- hw/pdm_pin_mux.sv ----
// pin function mux for six port d lines and two port e lines
// assumes gpio, memory, can and serial engines sit outside and talk through plain ports
`timescale 1ns/1ps
// Contract
// - port d line 0 resets to gpio and its enable bit 0 hands it to a peripheral.
// - with line 0 peripheral-owned, select bit 4 picks chip select two or second can transmit.
// - port d line 1 resets to gpio and its enable bit 1 hands it to a peripheral.
// - with line 1 peripheral-owned, select bit 5 picks chip select three or second can receive.
// - lines 2 to 5 reset to gpio and as peripherals carry chip selects four to seven.
// - every gpio line on port d and e has its own input or output direction.
// - chip selects float while the bus is idle unless bus idle drive is set.
// - clearing port d pull-up bit n turns off the pull-up on line n for lines 0 and 2 to 5, and for line 1 unless it is second can receive.
// - the second can receive pin keeps its pull-up on while that function is selected.
// - the serial0 transmit / port e line 0 pin resets to serial transmit.
// - the serial0 receive / port e line 1 pin resets to the serial function.
// - clearing port e pull-up bit 0 or 1 turns off the pull-up on that line.
module pdm_pin_mux (
  input wire logic core_clk,
  input wire logic reset,
  // configuration writes (plain ports, loaded when the strobe is high)
  input wire logic cfg_write,
  input wire logic [5:0] port_d_peripheral_enable,
  input wire logic [1:0] port_e_peripheral_enable,
  input wire logic [15:0] peripheral_select_reg,
  input wire logic [5:0] port_d_pullup_enable,
  input wire logic [1:0] port_e_pullup_enable,
  input wire logic bus_idle_drive,
  // configuration readback
  output logic [5:0] port_d_peripheral_enable_rd,
  output logic [1:0] port_e_peripheral_enable_rd,
  output logic [15:0] peripheral_select_rd,
  output logic [5:0] port_d_pullup_rd,
  output logic [1:0] port_e_pullup_rd,
  output logic bus_idle_drive_rd,
  // gpio data path
  input wire logic [5:0] port_d_gpio_out,
  input wire logic [5:0] port_d_gpio_dir,
  output logic [5:0] port_d_gpio_in,
  input wire logic [1:0] port_e_gpio_out,
  input wire logic [1:0] port_e_gpio_dir,
  output logic [1:0] port_e_gpio_in,
  // external memory interface, chip selects two to seven, active low
  input wire logic [5:0] chip_select_n,
  input wire logic bus_active,
  // second can
  input wire logic second_can_transmit,
  output logic second_can_receive,
  // serial port zero
  input wire logic serial0_transmit,
  output logic serial0_receive,
  // pads
  input wire logic [5:0] port_d_pad_in,
  output logic [5:0] port_d_pad_out,
  output logic [5:0] port_d_pad_oe,
  output logic [5:0] port_d_pad_pull,
  input wire logic [1:0] port_e_pad_in,
  output logic [1:0] port_e_pad_out,
  output logic [1:0] port_e_pad_oe,
  output logic [1:0] port_e_pad_pull
);
  // ==========================================================
  // state
  typedef struct packed {
    pdm_pkg::pdm_cfg_type cfg;
    logic [15:0] psel;
    pdm_pkg::pdm_pad_type [5:0] pd_pad;
    pdm_pkg::pdm_pad_type [1:0] pe_pad;
    logic [5:0] pd_in;
    logic [1:0] pe_in;
    logic can_rx;
    logic sci_rx;
  } pdm_state_type;

  pdm_state_type st_q;
  pdm_state_type st_d;
  logic [5:0] pd_sync;
  logic [1:0] pe_sync;

  // ==========================================================
  // pad input synchronisers
  pdm_sync #(
    .WIDTH(pdm_pkg::PD_LINES + pdm_pkg::PE_LINES)
  ) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({port_e_pad_in, port_d_pad_in}),
    .sync_out({pe_sync, pd_sync})
  );

  // ==========================================================
  // next state
  always_comb begin
    logic cs_drive;
    cs_drive = 1'b0;
    st_d = st_q;
    if (cfg_write) begin
      st_d.cfg.pd_per = port_d_peripheral_enable;
      st_d.cfg.pe_per = port_e_peripheral_enable;
      st_d.psel = peripheral_select_reg;
      st_d.cfg.can_tx_sel = peripheral_select_reg[pdm_pkg::SEL_CAN_TX_BIT];
      st_d.cfg.can_rx_sel = peripheral_select_reg[pdm_pkg::SEL_CAN_RX_BIT];
      st_d.cfg.pd_pull = port_d_pullup_enable;
      st_d.cfg.pe_pull = port_e_pullup_enable;
      st_d.cfg.bus_idle_drive = bus_idle_drive;
    end
    // chip selects float on an idle bus unless told to keep driving
    cs_drive = bus_active | st_q.cfg.bus_idle_drive;
    st_d.can_rx = 1'b1;
    st_d.sci_rx = 1'b1;
    for (int i = 0; i < 6; i++) begin
      st_d.pd_pad[i].pull = st_q.cfg.pd_pull[i];
      if (!st_q.cfg.pd_per[i]) begin
        st_d.pd_pad[i].out = port_d_gpio_out[i];
        st_d.pd_pad[i].oe = port_d_gpio_dir[i];
        st_d.pd_in[i] = pd_sync[i];
      end else begin
        // gpio direction and data are ignored here
        st_d.pd_in[i] = 1'b0;
        st_d.pd_pad[i].out = chip_select_n[i];
        st_d.pd_pad[i].oe = cs_drive;
      end
    end
    if (st_q.cfg.pd_per[0] && st_q.cfg.can_tx_sel) begin
      // open drain: only ever pull low
      st_d.pd_pad[0].out = 1'b0;
      st_d.pd_pad[0].oe = ~second_can_transmit;
    end
    if (st_q.cfg.pd_per[1] && st_q.cfg.can_rx_sel) begin
      st_d.pd_pad[1].out = 1'b0;
      st_d.pd_pad[1].oe = 1'b0;
      st_d.pd_pad[1].pull = 1'b1;
      st_d.can_rx = pd_sync[1];
    end
    for (int j = 0; j < 2; j++) begin
      st_d.pe_pad[j].pull = st_q.cfg.pe_pull[j];
      if (!st_q.cfg.pe_per[j]) begin
        st_d.pe_pad[j].out = port_e_gpio_out[j];
        st_d.pe_pad[j].oe = port_e_gpio_dir[j];
        st_d.pe_in[j] = pe_sync[j];
      end else begin
        st_d.pe_in[j] = 1'b0;
        st_d.pe_pad[j].out = (j == 0) ? serial0_transmit : 1'b0;
        st_d.pe_pad[j].oe = (j == 0);
      end
    end
    if (st_q.cfg.pe_per[1]) begin
      st_d.sci_rx = pe_sync[1];
    end
  end

  // ==========================================================
  // register; pads come up as pulled-up inputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q.cfg.pd_per <= pdm_pkg::PD_PER_RESET;
      st_q.cfg.pe_per <= pdm_pkg::PE_PER_RESET;
      st_q.cfg.pd_pull <= pdm_pkg::PD_PULL_RESET;
      st_q.cfg.pe_pull <= pdm_pkg::PE_PULL_RESET;
      st_q.cfg.can_tx_sel <= 1'b0;
      st_q.cfg.can_rx_sel <= 1'b0;
      st_q.cfg.bus_idle_drive <= pdm_pkg::BUS_IDLE_DRIVE_RESET;
      st_q.psel <= pdm_pkg::PSEL_RESET;
      st_q.pd_pad <= '{default: '{out: 1'b0, oe: 1'b0, pull: 1'b1}};
      st_q.pe_pad <= '{default: '{out: 1'b0, oe: 1'b0, pull: 1'b1}};
      st_q.pd_in <= 6'h00;
      st_q.pe_in <= 2'h0;
      st_q.can_rx <= 1'b1;
      st_q.sci_rx <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      port_d_pad_out[k] = st_q.pd_pad[k].out;
      port_d_pad_oe[k] = st_q.pd_pad[k].oe;
      port_d_pad_pull[k] = st_q.pd_pad[k].pull;
    end
    for (int m = 0; m < 2; m++) begin
      port_e_pad_out[m] = st_q.pe_pad[m].out;
      port_e_pad_oe[m] = st_q.pe_pad[m].oe;
      port_e_pad_pull[m] = st_q.pe_pad[m].pull;
    end
  end

  assign port_d_gpio_in = st_q.pd_in;
  assign port_e_gpio_in = st_q.pe_in;
  assign second_can_receive = st_q.can_rx;
  assign serial0_receive = st_q.sci_rx;
  assign port_d_peripheral_enable_rd = st_q.cfg.pd_per;
  assign port_e_peripheral_enable_rd = st_q.cfg.pe_per;
  assign peripheral_select_rd = st_q.psel;
  assign port_d_pullup_rd = st_q.cfg.pd_pull;
  assign port_e_pullup_rd = st_q.cfg.pe_pull;
  assign bus_idle_drive_rd = st_q.cfg.bus_idle_drive;
endmodule : pdm_pin_mux

// ---- test/pdm_pin_mux_properties.sv ----
// concurrent checks for the port d / port e pin mux
// assumes a bind onto pdm_pin_mux, one clock, sync reset
`timescale 1ns/1ps
module pdm_pin_mux_properties (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cfg_write,
  input wire logic [5:0] port_d_peripheral_enable,
  input wire logic [5:0] port_d_peripheral_enable_rd,
  input wire logic [1:0] port_e_peripheral_enable_rd,
  input wire logic [15:0] peripheral_select_rd,
  input wire logic [5:0] port_d_pullup_rd,
  input wire logic bus_idle_drive_rd,
  input wire logic [5:0] port_d_gpio_dir,
  input wire logic [5:0] port_d_gpio_in,
  input wire logic [5:0] chip_select_n,
  input wire logic bus_active,
  input wire logic second_can_transmit,
  input wire logic serial0_transmit,
  input wire logic [5:0] port_d_pad_out,
  input wire logic [5:0] port_d_pad_oe,
  input wire logic [5:0] port_d_pad_pull,
  input wire logic [1:0] port_e_pad_out,
  input wire logic [1:0] port_e_pad_oe
);
  wire logic [5:0] per = port_d_peripheral_enable_rd;
  wire logic drv = bus_active | bus_idle_drive_rd;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ==========================================
  // checks
  chk_cfg_load: assert property (cfg_write |=> per == $past(port_d_peripheral_enable))
    else $error("enable readback wrong");
  chk_gpio_drive: assert property (1 |=> (port_d_pad_oe & ~$past(per)) == $past(port_d_gpio_dir & ~per))
    else $error("gpio drive wrong");
  chk_line0_route: assert property (per[0] |=> port_d_pad_oe[0] == $past(peripheral_select_rd[4] ?
    !second_can_transmit : drv) && port_d_pad_out[0] == $past(!peripheral_select_rd[4] & chip_select_n[0]))
    else $error("line 0 routing wrong");
  chk_cs_float: assert property (&per[5:2] |=> port_d_pad_oe[5:2] == {4{$past(drv)}}
    && port_d_pad_out[5:2] == $past(chip_select_n[5:2])) else $error("chip select drive wrong");
  chk_can_rx_pull: assert property (per[1] && peripheral_select_rd[5] |=> !port_d_pad_oe[1]
    && port_d_pad_pull[1]) else $error("can receive pin wrong");
  chk_pd_pull: assert property (1 |=> port_d_pad_pull[5:2] == $past(port_d_pullup_rd[5:2]))
    else $error("pull-up wrong");
  chk_serial_tx: assert property (port_e_peripheral_enable_rd[0] |=> port_e_pad_oe[0]
    && port_e_pad_out[0] == $past(serial0_transmit)) else $error("serial transmit wrong");
  chk_periph_in_zero: assert property (&per[5:2] && $past(&per[5:2]) |-> port_d_gpio_in[5:2] == 4'h0)
    else $error("gpio input leaks");
endmodule : pdm_pin_mux_properties
bind pdm_pin_mux pdm_pin_mux_properties pdm_pin_mux_properties_inst (.*);

// ---- test/pdm_pin_mux_tb_top.sv ----
// directed bench for the port d / port e pin mux
// assumes pdm_pin_mux and its bound checker are compiled first
`timescale 1ns/1ps
module pdm_pin_mux_tb_top;
  logic core_clk = 1'b0, reset = 1'b1, cfg_write = 1'b0, bus_idle_drive = 1'b0, bus_active = 1'b0;
  logic second_can_transmit = 1'b1, serial0_transmit = 1'b1, second_can_receive, serial0_receive, bus_idle_drive_rd;
  logic [5:0] port_d_peripheral_enable = 6'h00, port_d_pullup_enable = 6'h3f, port_d_gpio_out = 6'h00;
  logic [5:0] port_d_gpio_dir = 6'h00, chip_select_n = 6'h3f, port_d_pad_in = 6'h3f;
  logic [5:0] port_d_peripheral_enable_rd, port_d_pullup_rd, port_d_gpio_in, port_d_pad_out, port_d_pad_oe;
  logic [5:0] port_d_pad_pull;
  logic [1:0] port_e_peripheral_enable = 2'h3, port_e_pullup_enable = 2'h3, port_e_gpio_out = 2'h0;
  logic [1:0] port_e_gpio_dir = 2'h0, port_e_pad_in = 2'h3;
  logic [1:0] port_e_peripheral_enable_rd, port_e_pullup_rd, port_e_gpio_in, port_e_pad_out, port_e_pad_oe;
  logic [1:0] port_e_pad_pull;
  logic [15:0] peripheral_select_reg = 16'h0000, peripheral_select_rd;
  int miscompares = 0;
  int checks = 0;
  always #2.5 core_clk = ~core_clk;
  pdm_pin_mux pdm_pin_mux_inst (.*);
  // ==========================================
  // helpers
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // loaded as one group; sync path needs a few cycles to settle after
  task cfg(input logic [5:0] dp, input logic [1:0] ep, input logic [15:0] sel, input logic [5:0] du,
      input logic [1:0] eu, input logic idle);
    @(posedge core_clk);
    cfg_write <= 1'b1;
    port_d_peripheral_enable <= dp;
    port_e_peripheral_enable <= ep;
    peripheral_select_reg <= sel;
    port_d_pullup_enable <= du;
    port_e_pullup_enable <= eu;
    bus_idle_drive <= idle;
    @(posedge core_clk);
    cfg_write <= 1'b0;
    cyc(6);
  endtask : cfg
  task summarize;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // ==========================================
  // scenarios
  task t_reset;
    cmp(port_d_peripheral_enable_rd, 16'h00);
    cmp(port_e_peripheral_enable_rd, 16'h3);
    cmp({port_d_pad_oe, port_d_pad_pull}, 16'h3f);
  endtask : t_reset
  task t_gpio;
    cfg(6'h00, 2'h0, 16'h0000, 6'h15, 2'h2, 1'b0);
    @(posedge core_clk);
    port_d_gpio_dir <= 6'h2a;
    port_d_gpio_out <= 6'h3f;
    port_e_gpio_dir <= 2'h1;
    port_e_gpio_out <= 2'h1;
    port_d_pad_in <= 6'h2d;
    port_e_pad_in <= 2'h2;
    cyc(6);
    cmp({port_d_pad_oe, port_d_pad_out & 6'h2a}, 16'haaa);
    cmp({port_e_pad_oe, port_e_pad_out[0], port_d_gpio_in, port_e_gpio_in}, 16'h3b6);
    cmp({port_d_pad_pull, port_e_pad_pull}, 16'h56);
    cmp({port_d_pullup_rd, port_e_pullup_rd}, 16'h56);
  endtask : t_gpio
  task t_cs;
    cfg(6'h3f, 2'h0, 16'h0000, 6'h3f, 2'h3, 1'b0);
    chip_select_n <= 6'h2a;
    cyc(2);
    cmp({port_d_pad_oe, port_d_gpio_in}, 16'h000);
    bus_active <= 1'b1;
    cyc(2);
    cmp({port_d_pad_oe, port_d_pad_out}, 16'hfea);
    bus_active <= 1'b0;
    cfg(6'h3f, 2'h0, 16'h0000, 6'h3f, 2'h3, 1'b1);
    cmp(port_d_pad_oe, 16'h3f);
  endtask : t_cs
  task t_can;
    cfg(6'h03, 2'h0, 16'h0030, 6'h00, 2'h3, 1'b1);
    second_can_transmit <= 1'b0;
    port_d_pad_in <= 6'h3d;
    cyc(6);
    cmp({port_d_pad_oe[1:0], port_d_pad_out[0], port_d_pad_pull[1], second_can_receive}, 16'h0a);
    cmp(peripheral_select_rd, 16'h0030);
    cmp(bus_idle_drive_rd, 16'h1);
    second_can_transmit <= 1'b1;
    cyc(2);
    cmp(port_d_pad_oe[0], 16'h0);
    chip_select_n <= 6'h2b;
    cfg(6'h03, 2'h0, 16'h0000, 6'h00, 2'h3, 1'b1);
    cmp({port_d_pad_out[1:0], port_d_pad_oe[1:0], second_can_receive}, 16'h1f);
  endtask : t_can
  task t_serial;
    cfg(6'h00, 2'h3, 16'h0000, 6'h3f, 2'h3, 1'b1);
    serial0_transmit <= 1'b0;
    port_e_pad_in <= 2'h1;
    cyc(6);
    cmp({port_e_pad_oe, port_e_pad_out[0], serial0_receive, port_e_gpio_in}, 16'h10);
  endtask : t_serial
  initial begin
    cyc(5);
    reset <= 1'b0;
    cyc(1);
    t_reset();
    t_gpio();
    t_cs();
    t_can();
    t_serial();
    summarize();
  end
endmodule : pdm_pin_mux_tb_top
